/* design/mfio_pkg.sv */
// Package for the multi-function I/O port block: offsets, reset values and carrier structs.
package mfio_pkg;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [4:0] OUT_LATCH_A_IDX = 5'h00;
    localparam logic [4:0] OUT_LATCH_B_IDX = 5'h01;
    localparam logic [4:0] OUT_LATCH_C_IDX = 5'h02;
    localparam logic [4:0] IN_SNAP_A_IDX   = 5'h0e;
    localparam logic [4:0] IN_SNAP_B_IDX   = 5'h0f;
    localparam logic [4:0] IN_SNAP_C_IDX   = 5'h10;
    localparam logic [4:0] CFG_DIR_A_IDX   = 5'h04;
    localparam logic [4:0] CFG_ALT_A_IDX   = 5'h0c;
    localparam logic [4:0] CFG_DIR_B_IDX   = 5'h0d;
    localparam logic [4:0] CFG_ANA_B_IDX   = 5'h0e;
    localparam logic [4:0] CFG_DIR_C_IDX   = 5'h0b;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OUT_LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST       = 8'hff;
    localparam logic [7:0] ALT_RST       = 8'hff;
    localparam logic [7:0] ANA_RST       = 8'h00;
    localparam logic [7:0] SNAP_RST      = 8'h00;

    // Small variant second port keeps lines 0 to 3 and 7.
    localparam logic [7:0] SMALL_B_MASK  = 8'h8f;
    localparam logic [7:0] PORT_C_MASK   = 8'h1f;
    // First-port lines that carry the mains sync inputs, lines 1 and 2.
    localparam logic [7:0] MAINS_SYNC_MASK = 8'h06;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic [4:0] addr;
        logic [7:0] data;
    } mfio_wr_s;

    typedef struct packed {
        logic       rdEn;
        logic [4:0] addr;
    } mfio_rd_s;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } mfio_pins_s;

endpackage

/* design/mfio_ports.sv */
// Multi-function I/O ports: output latches, input snapshots, configuration and pin drive.
`timescale 1ns/1ps
// What this block does
// - Large variant: ports of 8, 8 and 5 lines, 21 lines in total.
// - Small variant: 8-line port and 5-line port of lines 0-3 and 7.
// - Every line chooses input or output on its own; first-port lines may also take the alternate function.
// - Ports move whole; output lines read the buffer; writes always reach the buffer.
// - Pull-up drops for analog lines and for mains sync lines in triac sync modes.
// - Direction bit at one makes the line an input.
// - Direction bit at zero makes the line a digital output, except on an analog second-port line.
// - Pin levels are captured into input registers 14, 15 and 16.
// - Output registers 0, 1 and 2 drive the three ports.
// - Each port has a direction register; the first port adds an alternate-function register, the second an analog one.
// - Configuration registers 4 and 12, 13 and 14, and 11.
// - First port direction: zero digital output, one alternate-function input.
// - First port alternate: zero peripheral output, one ordinary digital I/O.
// - Second port analog register: one analog, zero digital, resets to zeros.
// - An analog second-port line has its output driver switched off.
module mfio_ports #(
    parameter bit          LARGE_VARIANT = 1'b1,
    parameter bit          HAS_PULLUP    = 1'b1
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // Core write side (output latches and configuration)
    input  wire mfio_pkg::mfio_wr_s    outWr,
    input  wire mfio_pkg::mfio_wr_s    cfgWr,
    // Core read side (input snapshots)
    input  wire mfio_pkg::mfio_rd_s    inRd,
    output logic [7:0]                 rdData,
    // Peripheral connections
    input  wire mfio_pkg::mfio_pins_s  periphOut,
    input  wire logic                  triacSyncMode,
    output mfio_pkg::mfio_pins_s       periphIn,
    output logic [7:0]                 analogSel,
    // Pins
    input  wire mfio_pkg::mfio_pins_s  pinIn,
    output mfio_pkg::mfio_pins_s       pinOut,
    output mfio_pkg::mfio_pins_s       pinOe_n,
    output mfio_pkg::mfio_pins_s       pullUpEn
);

    // ------------------------------------------------------------
    // Line masks per variant
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_B = LARGE_VARIANT ? 8'hff : mfio_pkg::SMALL_B_MASK;
    localparam logic [7:0] MASK_C = LARGE_VARIANT ? mfio_pkg::PORT_C_MASK : 8'h00;

    logic [7:0] latchA_q, latchB_q, latchC_q;
    logic [7:0] dirA_q, altA_q, dirB_q, anaB_q, dirC_q;
    logic [7:0] snapA_q, snapB_q, snapC_q;
    logic [7:0] drvA_d, drvB_d, drvC_d;
    logic [7:0] oeA_d, oeB_d, oeC_d;
    logic [7:0] pullA_d, pullB_d, pullC_d;
    logic [7:0] inA_d, inB_d, inC_d;

    // ------------------------------------------------------------
    // Output latches
    // ------------------------------------------------------------
    // A write lands in the latch whatever the line direction, so a later switch
    // to output shows the last written value.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latchA_q <= mfio_pkg::OUT_LATCH_RST;
            latchB_q <= mfio_pkg::OUT_LATCH_RST;
            latchC_q <= mfio_pkg::OUT_LATCH_RST;
        end else if (outWr.wrEn) begin
            case (outWr.addr)
                mfio_pkg::OUT_LATCH_A_IDX: latchA_q <= outWr.data;
                mfio_pkg::OUT_LATCH_B_IDX: latchB_q <= outWr.data & MASK_B;
                mfio_pkg::OUT_LATCH_C_IDX: latchC_q <= outWr.data & MASK_C;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Direction registers come up at all ones, so every line starts as an input.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dirA_q <= mfio_pkg::DIR_RST;
        end else if (cfgWr.wrEn && cfgWr.addr == mfio_pkg::CFG_DIR_A_IDX) begin
            dirA_q <= cfgWr.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            altA_q <= mfio_pkg::ALT_RST;
        end else if (cfgWr.wrEn && cfgWr.addr == mfio_pkg::CFG_ALT_A_IDX) begin
            altA_q <= cfgWr.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dirB_q <= mfio_pkg::DIR_RST;
        end else if (cfgWr.wrEn && cfgWr.addr == mfio_pkg::CFG_DIR_B_IDX) begin
            dirB_q <= cfgWr.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            anaB_q <= mfio_pkg::ANA_RST;
        end else if (cfgWr.wrEn && cfgWr.addr == mfio_pkg::CFG_ANA_B_IDX) begin
            anaB_q <= cfgWr.data & MASK_B;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dirC_q <= mfio_pkg::DIR_RST;
        end else if (cfgWr.wrEn && cfgWr.addr == mfio_pkg::CFG_DIR_C_IDX) begin
            dirC_q <= cfgWr.data;
        end
    end

    // ------------------------------------------------------------
    // Input snapshots
    // ------------------------------------------------------------
    // Output lines snapshot their own latch bit, so a port read returns the buffer.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            snapA_q <= mfio_pkg::SNAP_RST;
            snapB_q <= mfio_pkg::SNAP_RST;
            snapC_q <= mfio_pkg::SNAP_RST;
        end else begin
            snapA_q <= (dirA_q & pinIn.a) | (~dirA_q & latchA_q);
            snapB_q <= ((dirB_q & pinIn.b) | (~dirB_q & latchB_q)) & MASK_B & ~anaB_q;
            snapC_q <= ((dirC_q & pinIn.c) | (~dirC_q & latchC_q)) & MASK_C;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read data holds between reads, so software may copy it at leisure.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdData <= 8'h00;
        end else if (inRd.rdEn) begin
            case (inRd.addr)
                mfio_pkg::IN_SNAP_A_IDX: rdData <= snapA_q;
                mfio_pkg::IN_SNAP_B_IDX: rdData <= snapB_q;
                mfio_pkg::IN_SNAP_C_IDX: rdData <= snapC_q;
                default:                 rdData <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-line drive selection
    // ------------------------------------------------------------
    // Each line settles its own drive, enable, pull-up and peripheral input, so
    // inputs and outputs mix freely inside one port.
    for (genvar i = 0; i < 8; i++) begin : g_line
        // First port: alternate register at zero hands the line to the peripheral.
        assign drvA_d[i]  = altA_q[i] ? latchA_q[i] : periphOut.a[i];
        assign oeA_d[i]   = dirA_q[i];
        assign drvB_d[i]  = latchB_q[i];
        assign oeB_d[i]   = dirB_q[i] | anaB_q[i] | ~MASK_B[i];
        assign drvC_d[i]  = latchC_q[i];
        assign oeC_d[i]   = dirC_q[i] | ~MASK_C[i];
        // The mains sync lines lose their pull-up while the triac driver follows the mains.
        assign pullA_d[i] = HAS_PULLUP & ~(triacSyncMode & mfio_pkg::MAINS_SYNC_MASK[i]);
        assign pullB_d[i] = HAS_PULLUP & MASK_B[i] & ~anaB_q[i];
        assign pullC_d[i] = HAS_PULLUP & MASK_C[i];
        // Only lines set as inputs pass their level on, so a driven line never echoes back.
        assign inA_d[i]   = pinIn.a[i] & dirA_q[i];
        assign inB_d[i]   = pinIn.b[i] & dirB_q[i] & MASK_B[i];
        assign inC_d[i]   = pinIn.c[i] & dirC_q[i] & MASK_C[i];
    end

    // ------------------------------------------------------------
    // Registered pin outputs
    // ------------------------------------------------------------
    // Pins come from flops, so a write reaches the pin exactly one edge after the
    // latch takes it, with no decode glitch in between.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinOut <= '0;
        end else begin
            pinOut <= '{a: drvA_d, b: drvB_d, c: drvC_d};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinOe_n <= '1;
        end else begin
            pinOe_n <= '{a: oeA_d, b: oeB_d, c: oeC_d};
        end
    end

    // Pull-ups stay off during reset and come on at the first edge after it.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pullUpEn <= '0;
        end else begin
            pullUpEn <= '{a: pullA_d, b: pullB_d, c: pullC_d};
        end
    end

    // ------------------------------------------------------------
    // Registered peripheral outputs
    // ------------------------------------------------------------
    // Alternate-function inputs, such as the external timer clock on line 5.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            periphIn <= '0;
        end else begin
            periphIn <= '{a: inA_d, b: inB_d, c: inC_d};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            analogSel <= 8'h00;
        end else begin
            analogSel <= anaB_q;
        end
    end

endmodule

/* tb/mfio_ports_props.sv */
// Checker for the multi-function I/O ports, bound to the top module.
`timescale 1ns/1ps
module mfio_ports_props #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter bit HAS_PULLUP    = 1'b1
) (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    // Core side
    input wire mfio_pkg::mfio_wr_s   outWr,
    input wire mfio_pkg::mfio_wr_s   cfgWr,
    input wire mfio_pkg::mfio_rd_s   inRd,
    input wire logic [7:0]           rdData,
    // Peripheral side
    input wire mfio_pkg::mfio_pins_s periphOut,
    input wire logic                 triacSyncMode,
    input wire mfio_pkg::mfio_pins_s periphIn,
    input wire logic [7:0]           analogSel,
    // Pins
    input wire mfio_pkg::mfio_pins_s pinIn,
    input wire mfio_pkg::mfio_pins_s pinOut,
    input wire mfio_pkg::mfio_pins_s pinOe_n,
    input wire mfio_pkg::mfio_pins_s pullUpEn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence wrLatchB;
        outWr.wrEn && outWr.addr == 5'h01;
    endsequence
    sequence rdPortC;
        inRd.rdEn && inRd.addr == 5'h10;
    endsequence
    latch_to_pin_a: assert property (wrLatchB |-> ##2 ((pinOut.b ^ $past(outWr.data, 2)) & ~pinOe_n.b) == 8'h00)
        else $error("port B pin does not follow its latch");
    unmapped_read_a: assert property (inRd.rdEn && inRd.addr == 5'h03 |=> rdData == 8'h00)
        else $error("unmapped read returned nonzero");
    read_hold_a: assert property (!inRd.rdEn |=> $stable(rdData))
        else $error("read data changed without a read");
    port_c_width_a: assert property (pinOe_n.c[7:5] == 3'b111 && pullUpEn.c[7:5] == 3'b000)
        else $error("absent port C line is active");
    port_c_read_a: assert property (rdPortC |=> rdData[7:5] == 3'b000)
        else $error("absent port C line read nonzero");
    analog_tristate_a: assert property ((analogSel & ~pinOe_n.b) == 8'h00)
        else $error("analog line is driven");
    analog_pullup_a: assert property ((analogSel & pullUpEn.b) == 8'h00)
        else $error("analog line keeps its pull-up");
    triac_pullup_a: assert property (triacSyncMode [*2] |-> pullUpEn.a[2:1] == 2'b00)
        else $error("mains sync line keeps its pull-up");
    output_no_input_a: assert property ((periphIn.a & ~pinOe_n.a) == 8'h00)
        else $error("output line seen as peripheral input");
    input_gate_a: assert property (((periphIn.b & ~pinOe_n.b) | (periphIn.c & ~pinOe_n.c)) == 8'h00)
        else $error("driven line of port B or C seen as peripheral input");
endmodule
bind mfio_ports mfio_ports_props #(.LARGE_VARIANT(LARGE_VARIANT), .HAS_PULLUP(HAS_PULLUP)) mfio_ports_props_i (
    .core_clk(core_clk), .rst_n(rst_n), .outWr(outWr), .cfgWr(cfgWr), .inRd(inRd), .rdData(rdData),
    .periphOut(periphOut), .triacSyncMode(triacSyncMode), .periphIn(periphIn), .analogSel(analogSel),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .pullUpEn(pullUpEn));

/* tb/mfio_pin_model.sv */
// Board model of the pins: external drive, pull-ups and the block's own drivers.
`timescale 1ns/1ps
module mfio_pin_model (
    // Block side
    input  wire mfio_pkg::mfio_pins_s pinOut,
    input  wire mfio_pkg::mfio_pins_s pinOe_n,
    input  wire mfio_pkg::mfio_pins_s pullUpEn,
    // Board side
    input  wire logic [23:0]          extVal,
    input  wire logic [23:0]          extEn,
    output mfio_pkg::mfio_pins_s      pinIn
);
    logic [23:0] level;
    // A floating line without pull-up shows the inverse board value, so a stale match cannot pass.
    assign level = (~pinOe_n & pinOut) | (pinOe_n & extEn & extVal) | (pinOe_n & ~extEn & (pullUpEn | ~extVal));
    assign pinIn = mfio_pkg::mfio_pins_s'(level);
endmodule

/* tb/mfio_ports_tb.sv */
// Self-checking testbench for the multi-function I/O ports.
`timescale 1ns/1ps
module mfio_ports_tb;
    logic                 core_clk      = 1'b0;
    logic                 rst_n         = 1'b0;
    mfio_pkg::mfio_wr_s   outWr         = '0;
    mfio_pkg::mfio_wr_s   cfgWr         = '0;
    mfio_pkg::mfio_rd_s   inRd          = '0;
    mfio_pkg::mfio_pins_s periphOut     = '0;
    logic                 triacSyncMode = 1'b0;
    logic [23:0]          extVal        = 24'ha53cff;
    logic [23:0]          extEn         = 24'hffffff;
    logic [7:0]           rdData;
    logic [7:0]           analogSel;
    mfio_pkg::mfio_pins_s periphIn, pinIn, pinOut, pinOe_n, pullUpEn;
    logic [7:0]           rdDataSm, analogSelSm;
    mfio_pkg::mfio_pins_s periphInSm, pinInSm, pinOutSm, pinOeSm_n, pullUpEnSm;
    int                   err_total     = 0;
    int                   check_count   = 0;
    always #5 core_clk = ~core_clk;
    mfio_ports #(.LARGE_VARIANT(1'b1), .HAS_PULLUP(1'b1)) mfio_ports_i (.core_clk(core_clk), .rst_n(rst_n),
        .outWr(outWr), .cfgWr(cfgWr), .inRd(inRd), .rdData(rdData), .periphOut(periphOut),
        .triacSyncMode(triacSyncMode), .periphIn(periphIn), .analogSel(analogSel), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe_n(pinOe_n), .pullUpEn(pullUpEn));
    mfio_pin_model mfio_pin_model_i (.pinOut(pinOut), .pinOe_n(pinOe_n), .pullUpEn(pullUpEn),
        .extVal(extVal), .extEn(extEn), .pinIn(pinIn));
    // The small variant without pull-ups sees the same core traffic and board.
    mfio_ports #(.LARGE_VARIANT(1'b0), .HAS_PULLUP(1'b0)) mfio_ports_small_i (.core_clk(core_clk), .rst_n(rst_n),
        .outWr(outWr), .cfgWr(cfgWr), .inRd(inRd), .rdData(rdDataSm), .periphOut(periphOut),
        .triacSyncMode(triacSyncMode), .periphIn(periphInSm), .analogSel(analogSelSm), .pinIn(pinInSm),
        .pinOut(pinOutSm), .pinOe_n(pinOeSm_n), .pullUpEn(pullUpEnSm));
    mfio_pin_model mfio_pin_model_small_i (.pinOut(pinOutSm), .pinOe_n(pinOeSm_n), .pullUpEn(pullUpEnSm),
        .extVal(extVal), .extEn(extEn), .pinIn(pinInSm));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input bit cfg, input logic [4:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        if (cfg) cfgWr = {1'b1, addr, data};
        else outWr = {1'b1, addr, data};
        @(negedge core_clk);
        cfgWr = '0;
        outWr = '0;
    endtask
    // Two idle cycles let new drive settle on the pins and into the snapshot.
    task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
        repeat (2) @(negedge core_clk);
        inRd = {1'b1, addr};
        @(negedge core_clk);
        inRd = '0;
        check(rdData, exp);
    endtask
    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        check(pinOe_n.a & pinOe_n.b, 8'hff);
        check(analogSel, 8'h00);
        check(pullUpEnSm.a | pullUpEnSm.b, 8'h00);
        check(pullUpEn.c, 8'h1f);
        rd(5'h0e, 8'ha5);
        check(rdData & 8'h20, 8'h20);
        rd(5'h0f, 8'h3c);
        check(rdDataSm, 8'h0c);
        rd(5'h10, 8'h1f);
        check(rdDataSm, 8'h00);
        rd(5'h03, 8'h00);
        wr(1'b1, 5'h04, 8'hf0);
        wr(1'b0, 5'h00, 8'h36);
        rd(5'h0e, 8'ha6);
        check(pinOe_n.a, 8'hf0);
        periphOut.a = 8'h01;
        wr(1'b1, 5'h0c, 8'hfe);
        rd(5'h0e, 8'ha6);
        check(pinOut.a & 8'h0f, 8'h07);
        extVal = 24'ha5ff1f;
        wr(1'b1, 5'h0e, 8'h03);
        wr(1'b1, 5'h0d, 8'hf0);
        wr(1'b0, 5'h01, 8'h5a);
        rd(5'h0f, 8'hf8);
        check(pinOe_n.b, 8'hf3);
        check(rdDataSm, 8'h88);
        check(analogSel, 8'h03);
        check(analogSelSm, 8'h03);
        check(pullUpEn.b & 8'h03, 8'h00);
        wr(1'b1, 5'h0b, 8'h00);
        wr(1'b0, 5'h02, 8'hea);
        rd(5'h10, 8'h0a);
        check(periphIn.c, 8'h00);
        check(periphIn.b, 8'hf0);
        check(periphInSm.c, 8'h00);
        wr(1'b1, 5'h04, 8'hff);
        check(pullUpEn.a, 8'hff);
        triacSyncMode = 1'b1;
        repeat (3) @(negedge core_clk);
        check(pullUpEn.a, 8'hf9);
        check(periphIn.a, 8'ha5);
        wrap_up();
    end
endmodule
